// >>> tmc_cfg.svh
// Constants for the two-channel temperature monitor core.
// Assumes inclusion by bare name from the core.
// Function
// - Convert continuously without external trigger
// - Alternate local and remote channel conversions
// - Store signed 8-bit result per channel
// - Compare against four limits, set flags
// - Any out-of-limit flag pulls alarm low
// - Alarm output is open-drain
// - Host writes limits/config, reads every register
// - Controls: standby, alarm mask, conversion rate
// - Standby pin low stops converting
// - Three-state address pins form bus address
// - Value registers reset to minus 128
// - Normal boot: measure both before comparing
// - Standby boot: defaults trip both low flags
// - Leave standby, status read clears if in-limit
// - Average 16 measurements per reported value
// - Data pin open-drain, clock input only
// - Status layout: busy 7, flags 6..2
// - Status read clears only vanished conditions
// - First written byte loads register pointer
// - Separate write addresses 09-0E, one-shot 0F
`ifndef TMC_CFG_SVH
`define TMC_CFG_SVH
// Register indexes; byte address on APB is four times the index
`define TMC_IDX_LVAL 8'h00
`define TMC_IDX_RVAL 8'h01
`define TMC_IDX_STAT 8'h02
`define TMC_IDX_CFG_R 8'h03
`define TMC_IDX_RATE_R 8'h04
`define TMC_IDX_LHI_R 8'h05
`define TMC_IDX_LLO_R 8'h06
`define TMC_IDX_RHI_R 8'h07
`define TMC_IDX_RLO_R 8'h08
`define TMC_IDX_CFG_W 8'h09
`define TMC_IDX_RATE_W 8'h0A
`define TMC_IDX_LHI_W 8'h0B
`define TMC_IDX_LLO_W 8'h0C
`define TMC_IDX_RHI_W 8'h0D
`define TMC_IDX_RLO_W 8'h0E
`define TMC_IDX_ONESHOT 8'h0F
// Reset values
`define TMC_RST_VAL 8'h80
`define TMC_RST_CFG 8'h00
`define TMC_RST_RATE 8'h02
`define TMC_RST_HI 8'h7F
`define TMC_RST_LO 8'hC9
// Field positions
`define TMC_STAT_BUSY 7
`define TMC_CFG_MASK 7
`define TMC_CFG_STANDBY_SELECT_N 6
// Timing, counts and SMBus base address
`define TMC_AVG_LAST 4'hF
`define TMC_RATE_MAX 8'h09
`define TMC_CLK_MHZ 40
`define TMC_GAP_UNIT_US 1000
`define TMC_SMB_BASE 7'h18
`endif

// >>> tmc_pkg.sv
// Types shared by the temperature monitor core.
// Assumes tmc_cfg.svh is on the include path.
package tmc_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tmc_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tmc_apb_rsp_t;
  typedef enum logic [1:0] {C_GAP, C_START, C_WAIT} tmc_conv_t;
  typedef enum logic [2:0] {M_IDLE, M_ADDR, M_ACK, M_WR, M_SEND, M_RACK} tmc_smb_t;
endpackage : tmc_pkg

// >>> tmc_core.sv
// Temperature monitor digital core: conversion sequencing, averaging,
// limit compare, status flags, open-drain alarm, APB and SMBus register access.
// Assumes an external ADC giving one sample per adc_start on the core clock.
`include "tmc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tmc_core #(
  parameter int GAP_UNIT_CYC = `TMC_GAP_UNIT_US * `TMC_CLK_MHZ
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire tmc_pkg::tmc_apb_req_t apb_req,
  output tmc_pkg::tmc_apb_rsp_t apb_rsp,
  input wire logic standby_select_n,
  input wire logic [1:0] addr_select_high,
  input wire logic [1:0] addr_select_low,
  input wire logic smb_clk,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  output logic alert_out,
  output logic alert_oe,
  input wire logic [7:0] adc_data,
  input wire logic adc_done,
  input wire logic remote_open,
  output logic adc_start,
  output logic adc_remote
);
  // =========================================================
  // Registers and helpers
  logic [7:0] lval_q, lval_d, rval_q, rval_d, cfg_q, cfg_d, rate_q, rate_d;
  logic [7:0] lhi_q, lhi_d, llo_q, llo_d, rhi_q, rhi_d, rlo_q, rlo_d;
  logic [4:0] flags_q, flags_d;
  logic cmp_en_q, cmp_en_d, oneshot_q, oneshot_d;
  logic busy;
  logic [6:0] my_addr_q, my_addr_d;
  logic [1:0] boot_q, boot_d;
  logic wr_en, rd_stat;
  logic [7:0] wr_idx, wr_data;

  function automatic logic [7:0] reg_read(input logic [7:0] idx);
    case (idx)
      `TMC_IDX_LVAL: reg_read = lval_q;
      `TMC_IDX_RVAL: reg_read = rval_q;
      `TMC_IDX_STAT: reg_read = {busy, flags_q, 2'b00};
      `TMC_IDX_CFG_R: reg_read = cfg_q;
      `TMC_IDX_RATE_R: reg_read = rate_q;
      `TMC_IDX_LHI_R: reg_read = lhi_q;
      `TMC_IDX_LLO_R: reg_read = llo_q;
      `TMC_IDX_RHI_R: reg_read = rhi_q;
      `TMC_IDX_RLO_R: reg_read = rlo_q;
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // Three-state pin code 0 low, 1 open, 2 high
  function automatic logic [6:0] pin_addr(input logic [1:0] hi, input logic [1:0] lo);
    pin_addr = 7'(`TMC_SMB_BASE + 7'(hi) * 7'h03 + 7'(lo));
  endfunction : pin_addr

  // =========================================================
  // Synchronisers for pins from outside the clock domain
  logic [1:0] standby_select_n_sy, scl_sy, sda_sy, open_sy;
  logic [1:0] ah1_q, ah2_q, al1_q, al2_q;
  logic scl_p, sda_p;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      standby_select_n_sy <= 2'h0; // Standby until the pin is seen, so boot cannot start a round
      scl_sy <= 2'h3;
      sda_sy <= 2'h3;
      open_sy <= 2'h0;
      ah1_q <= 2'h0;
      ah2_q <= 2'h0;
      al1_q <= 2'h0;
      al2_q <= 2'h0;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      standby_select_n_sy <= {standby_select_n_sy[0], standby_select_n};
      scl_sy <= {scl_sy[0], smb_clk};
      sda_sy <= {sda_sy[0], serial_data_pin_in};
      open_sy <= {open_sy[0], remote_open};
      ah1_q <= addr_select_high;
      ah2_q <= ah1_q;
      al1_q <= addr_select_low;
      al2_q <= al1_q;
      scl_p <= scl_sy[1];
      sda_p <= sda_sy[1];
    end
  end
  logic standby;
  assign standby = !standby_select_n_sy[1] || cfg_q[`TMC_CFG_STANDBY_SELECT_N];

  // =========================================================
  // APB slave, one wait state
  tmc_pkg::tmc_apb_rsp_t rsp_q, rsp_d;
  logic [7:0] a_idx;
  logic a_done, a_rd_ok, a_wr_ok;
  assign a_idx = apb_req.paddr[9:2];
  assign a_done = apb_req.psel && apb_req.penable && rsp_q.pready;
  // Cross-used addresses are refused with an error
  assign a_rd_ok = (apb_req.paddr[11:10] == 2'h0) && (a_idx <= `TMC_IDX_RLO_R);
  assign a_wr_ok = (apb_req.paddr[11:10] == 2'h0) && (a_idx >= `TMC_IDX_CFG_W)
                   && (a_idx <= `TMC_IDX_ONESHOT);
  always_comb begin
    rsp_d = '0;
    if (apb_req.psel && apb_req.penable && !rsp_q.pready) begin
      rsp_d.pready = 1'b1;
      rsp_d.pslverr = apb_req.pwrite ? !a_wr_ok : !a_rd_ok;
      rsp_d.prdata = (!apb_req.pwrite && a_rd_ok) ? {24'h0, reg_read(a_idx)} : 32'h0;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) rsp_q <= '0;
    else rsp_q <= rsp_d;
  end
  assign apb_rsp = rsp_q;

  // =========================================================
  // SMBus slave
  tmc_pkg::tmc_smb_t sm_q, sm_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d, rdv;
  logic [3:0] bit_q, bit_d;
  logic rw_q, rw_d, first_q, first_d, oe_q, oe_d, nack_q, nack_d;
  logic s_rise, s_fall, s_start, s_stop, s_wr, s_rds, load;
  assign s_rise = scl_sy[1] && !scl_p;
  assign s_fall = !scl_sy[1] && scl_p;
  assign s_start = scl_sy[1] && sda_p && !sda_sy[1];
  assign s_stop = scl_sy[1] && !sda_p && sda_sy[1];
  assign rdv = reg_read(ptr_q);
  always_comb begin
    sm_d = sm_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    bit_d = bit_q;
    rw_d = rw_q;
    first_d = first_q;
    oe_d = oe_q;
    nack_d = nack_q;
    s_wr = 1'b0;
    load = 1'b0;
    if (s_start) begin
      sm_d = tmc_pkg::M_ADDR;
      bit_d = 4'h0;
      oe_d = 1'b0;
      first_d = 1'b1;
    end else if (s_stop) begin
      sm_d = tmc_pkg::M_IDLE;
      oe_d = 1'b0;
    end else begin
      case (sm_q)
        tmc_pkg::M_ADDR, tmc_pkg::M_WR: begin
          if (s_rise) begin
            sh_d = {sh_q[6:0], sda_sy[1]};
            bit_d = 4'(bit_q + 4'h1);
          end else if (s_fall && bit_q == 4'h8) begin
            bit_d = 4'h0;
            if (sm_q == tmc_pkg::M_ADDR) begin
              if (sh_q[7:1] == my_addr_q) begin
                oe_d = 1'b1;
                rw_d = sh_q[0];
                sm_d = tmc_pkg::M_ACK;
              end else begin
                sm_d = tmc_pkg::M_IDLE;
              end
            end else begin
              oe_d = 1'b1;
              sm_d = tmc_pkg::M_ACK;
              if (first_q) begin
                ptr_d = sh_q;
                first_d = 1'b0;
              end else begin
                s_wr = 1'b1;
              end
            end
          end
        end
        tmc_pkg::M_ACK: begin
          if (s_fall) begin
            if (rw_q) load = 1'b1;
            else begin
              oe_d = 1'b0;
              sm_d = tmc_pkg::M_WR;
            end
          end
        end
        tmc_pkg::M_SEND: begin
          if (s_fall) begin
            if (bit_q == 4'h8) begin
              oe_d = 1'b0;
              sm_d = tmc_pkg::M_RACK;
            end else begin
              oe_d = !sh_q[7];
              sh_d = {sh_q[6:0], 1'b0};
              bit_d = 4'(bit_q + 4'h1);
            end
          end
        end
        tmc_pkg::M_RACK: begin
          if (s_rise) nack_d = sda_sy[1];
          else if (s_fall) begin
            if (nack_q) sm_d = tmc_pkg::M_IDLE;
            else load = 1'b1;
          end
        end
        default: sm_d = tmc_pkg::M_IDLE;
      endcase
    end
    if (load) begin
      oe_d = !rdv[7];
      sh_d = {rdv[6:0], 1'b0};
      bit_d = 4'h1;
      sm_d = tmc_pkg::M_SEND;
    end
    s_rds = load && ptr_q == `TMC_IDX_STAT;
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sm_q <= tmc_pkg::M_IDLE;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      bit_q <= 4'h0;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      oe_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      sm_q <= sm_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      bit_q <= bit_d;
      rw_q <= rw_d;
      first_q <= first_d;
      oe_q <= oe_d;
      nack_q <= nack_d;
    end
  end
  assign serial_data_pin_oe = oe_q;
  assign serial_data_pin_out = 1'b0;

  // Either port may write; APB wins a same-cycle collision
  assign wr_en = (a_done && apb_req.pwrite && a_wr_ok) || s_wr;
  assign wr_idx = (a_done && apb_req.pwrite && a_wr_ok) ? a_idx : ptr_q;
  assign wr_data = (a_done && apb_req.pwrite && a_wr_ok) ? apb_req.pwdata[7:0] : sh_q;
  assign rd_stat = (a_done && !apb_req.pwrite && a_idx == `TMC_IDX_STAT) || s_rds;

  // =========================================================
  // Conversion sequencer with 16-sample averaging
  tmc_pkg::tmc_conv_t cv_q, cv_d;
  logic [31:0] gap_q, gap_d;
  logic [3:0] n_q, n_d;
  logic signed [11:0] acc_q, acc_d;
  logic chan_q, chan_d, start_q, start_d, both_q, both_d;
  logic [3:0] gap_sh;
  assign gap_sh = 4'(`TMC_RATE_MAX - ((rate_q > `TMC_RATE_MAX) ? `TMC_RATE_MAX : rate_q));
  assign busy = cv_q != tmc_pkg::C_GAP;
  always_comb begin
    cv_d = cv_q;
    gap_d = gap_q;
    n_d = n_q;
    acc_d = acc_q;
    chan_d = chan_q;
    start_d = 1'b0;
    both_d = both_q;
    lval_d = lval_q;
    rval_d = rval_q;
    oneshot_d = oneshot_q;
    case (cv_q)
      tmc_pkg::C_GAP: begin
        if (gap_q != 32'h0) gap_d = 32'(gap_q - 32'h1);
        else if (!standby || oneshot_q) cv_d = tmc_pkg::C_START;
      end
      tmc_pkg::C_START: begin
        start_d = 1'b1;
        cv_d = tmc_pkg::C_WAIT;
      end
      tmc_pkg::C_WAIT: begin
        if (adc_done) begin
          acc_d = 12'(acc_q + {{4{adc_data[7]}}, adc_data});
          n_d = 4'(n_q + 4'h1);
          cv_d = tmc_pkg::C_START;
          if (n_q == `TMC_AVG_LAST) begin
            acc_d = 12'sh000;
            if (chan_q) begin
              rval_d = acc_d[11:4];
              both_d = 1'b1;
              oneshot_d = 1'b0;
              cv_d = tmc_pkg::C_GAP;
              gap_d = 32'(GAP_UNIT_CYC) << gap_sh;
            end else begin
              lval_d = acc_d[11:4];
            end
            chan_d = !chan_q;
          end
        end
      end
      default: cv_d = tmc_pkg::C_GAP;
    endcase
    // Taken from the final sum before it is cleared
    if (cv_q == tmc_pkg::C_WAIT && adc_done && n_q == `TMC_AVG_LAST) begin
      if (chan_q) rval_d = 8'(12'(acc_q + {{4{adc_data[7]}}, adc_data}) >>> 4);
      else lval_d = 8'(12'(acc_q + {{4{adc_data[7]}}, adc_data}) >>> 4);
    end
    if (wr_en && wr_idx == `TMC_IDX_ONESHOT) oneshot_d = 1'b1;
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cv_q <= tmc_pkg::C_GAP;
      gap_q <= 32'h0;
      n_q <= 4'h0;
      acc_q <= 12'sh000;
      chan_q <= 1'b0;
      start_q <= 1'b0;
      both_q <= 1'b0;
      lval_q <= `TMC_RST_VAL;
      rval_q <= `TMC_RST_VAL;
      oneshot_q <= 1'b0;
    end else begin
      cv_q <= cv_d;
      gap_q <= gap_d;
      n_q <= n_d;
      acc_q <= acc_d;
      chan_q <= chan_d;
      start_q <= start_d;
      both_q <= both_d;
      lval_q <= lval_d;
      rval_q <= rval_d;
      oneshot_q <= oneshot_d;
    end
  end
  assign adc_start = start_q;
  assign adc_remote = chan_q;

  // =========================================================
  // Control registers, comparison, flags and alarm
  logic [4:0] trip;
  logic al_q, al_d;
  assign trip = {$signed(lval_q) > $signed(lhi_q), $signed(lval_q) < $signed(llo_q),
                 $signed(rval_q) > $signed(rhi_q), $signed(rval_q) < $signed(rlo_q),
                 open_sy[1]};
  always_comb begin
    cfg_d = cfg_q;
    rate_d = rate_q;
    lhi_d = lhi_q;
    llo_d = llo_q;
    rhi_d = rhi_q;
    rlo_d = rlo_q;
    if (wr_en) begin
      case (wr_idx)
        `TMC_IDX_CFG_W: cfg_d = wr_data;
        `TMC_IDX_RATE_W: rate_d = wr_data;
        `TMC_IDX_LHI_W: lhi_d = wr_data;
        `TMC_IDX_LLO_W: llo_d = wr_data;
        `TMC_IDX_RHI_W: rhi_d = wr_data;
        `TMC_IDX_RLO_W: rlo_d = wr_data;
        default: cfg_d = cfg_q;
      endcase
    end
    boot_d = (boot_q == 2'h3) ? boot_q : 2'(boot_q + 2'h1);
    my_addr_d = (boot_q == 2'h2) ? pin_addr(ah2_q, al2_q) : my_addr_q;
    // Standby boot compares the defaults at once; normal boot waits for both values
    cmp_en_d = cmp_en_q || both_q || (boot_q == 2'h2 && !standby_select_n_sy[1]);
    // A new trip wins over the read clear
    flags_d = (flags_q & ~({5{rd_stat}} & ~trip)) | (cmp_en_q ? trip : 5'h00);
    al_d = (|flags_q) && !cfg_q[`TMC_CFG_MASK];
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg_q <= `TMC_RST_CFG;
      rate_q <= `TMC_RST_RATE;
      lhi_q <= `TMC_RST_HI;
      llo_q <= `TMC_RST_LO;
      rhi_q <= `TMC_RST_HI;
      rlo_q <= `TMC_RST_LO;
      boot_q <= 2'h0;
      my_addr_q <= `TMC_SMB_BASE;
      cmp_en_q <= 1'b0;
      flags_q <= 5'h00;
      al_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      rate_q <= rate_d;
      lhi_q <= lhi_d;
      llo_q <= llo_d;
      rhi_q <= rhi_d;
      rlo_q <= rlo_d;
      boot_q <= boot_d;
      my_addr_q <= my_addr_d;
      cmp_en_q <= cmp_en_d;
      flags_q <= flags_d;
      al_q <= al_d;
    end
  end
  assign alert_oe = al_q;
  assign alert_out = 1'b0;
endmodule : tmc_core
`default_nettype wire

// >>> tmc_core_asserts.sv
// Concurrent checks on the temperature monitor core ports.
// Assumes tmc_pkg is compiled first; attached to every tmc_core by bind.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checker
module tmc_core_asserts (
  input wire logic clock,
  input wire logic rst_n,
  input wire tmc_pkg::tmc_apb_req_t apb_req,
  input wire tmc_pkg::tmc_apb_rsp_t apb_rsp,
  input wire logic serial_data_pin_out,
  input wire logic serial_data_pin_oe,
  input wire logic alert_out,
  input wire logic alert_oe,
  input wire logic adc_done,
  input wire logic adc_start
);
  logic [7:0] idx;
  logic bad;
  assign idx = apb_req.paddr[9:2];
  // Write and read windows differ, so the refusal test depends on direction
  assign bad = apb_req.pwrite ? (idx < 8'h09 || idx > 8'h0F) : (idx > 8'h08);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_sda_od; serial_data_pin_out == 1'h0; endproperty
  a_sda_od: assert property (p_sda_od) else $error("data pin driven high");
  property p_alert_od; alert_out == 1'h0; endproperty
  a_alert_od: assert property (p_alert_od) else $error("alarm pin driven high");
  // Must hold through reset itself, so the default disable is overridden
  property p_rst;
    disable iff (1'h0) !rst_n |=> !alert_oe && !adc_start && !apb_rsp.pready && !serial_data_pin_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("output active after reset");
  property p_wait; apb_req.psel && $rose(apb_req.penable) |=> apb_rsp.pready; endproperty
  a_wait: assert property (p_wait) else $error("ready not after one wait");
  property p_once; apb_rsp.pready |=> !apb_rsp.pready; endproperty
  a_once: assert property (p_once) else $error("ready longer than a cycle");
  property p_refuse;
    apb_rsp.pready && apb_req.psel && apb_req.paddr[11:10] == 2'h0 && bad
      |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0;
  endproperty
  a_refuse: assert property (p_refuse) else $error("wrong window accepted");
  property p_upper; apb_rsp.pready && !apb_rsp.pslverr |-> apb_rsp.prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("read data above byte");
  property p_done_gap; adc_done |-> !adc_start; endproperty
  a_done_gap: assert property (p_done_gap) else $error("start with done");
endmodule : tmc_core_asserts
bind tmc_core tmc_core_asserts u_chk (
  .clock(clock), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .serial_data_pin_out(serial_data_pin_out), .serial_data_pin_oe(serial_data_pin_oe),
  .alert_out(alert_out), .alert_oe(alert_oe), .adc_done(adc_done), .adc_start(adc_start)
);
`default_nettype wire

// >>> tmc_adc_model.sv
// Behavioural converter answering each sample request after a few cycles.
// Assumes the core clock domain; samples alternate base and base+2.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Converter model
module tmc_adc_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic adc_start,
  input wire logic adc_remote,
  input wire logic [7:0] lbase,
  input wire logic [7:0] rbase,
  output logic adc_done,
  output logic [7:0] adc_data
);
  logic [1:0] cnt;
  logic par;
  always_ff @(posedge clock) begin
    adc_done <= 1'h0;
    // Data is only valid with done; afterwards it shows garbage
    if (adc_done) adc_data <= ~adc_data;
    if (!rst_n) begin
      cnt <= 2'h0;
      par <= 1'h0;
      adc_data <= 8'h00;
    end else if (adc_start) begin
      cnt <= 2'h3;
    end else if (cnt != 2'h0) begin
      cnt <= cnt - 2'h1;
      if (cnt == 2'h1) begin
        adc_done <= 1'h1;
        adc_data <= (adc_remote ? rbase : lbase) + {6'h00, par, 1'h0};
        par <= ~par;
      end
    end
  end
endmodule : tmc_adc_model
`default_nettype wire

// >>> tb_temp_monitor_compare_alert.sv
// Self-checking bench for tmc_core over APB, a short SMBus frame and the converter.
// Assumes tmc_pkg, the checker and tmc_adc_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb_temp_monitor_compare_alert;
  logic clock = 1'h0, rst_n = 1'h0, standby_select_n = 1'h0, smb_clk = 1'h1, sda = 1'h1;
  logic remote_open = 1'h0;
  tmc_pkg::tmc_apb_req_t req = '0;
  tmc_pkg::tmc_apb_rsp_t rsp;
  logic sda_oe, sda_out, sda_line, alert_out, alert_oe, adc_done, adc_start, adc_remote, e, ack;
  logic [7:0] adc_data, q;
  logic [7:0] lbase = 8'h18, rbase = 8'h31;
  logic [7:0] rv [0:8] = '{8'h80, 8'h80, 8'h28, 8'h00, 8'h02, 8'h7F, 8'hC9, 8'h7F, 8'hC9};
  int n_errors = 0, compares = 0;
  assign sda_line = sda & ~sda_oe;
  always #12.5 clock = ~clock;
  // Short gap unit keeps a full conversion round near two hundred cycles
  tmc_core #(.GAP_UNIT_CYC(8)) uut (.clock(clock), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
    .standby_select_n(standby_select_n), .addr_select_high(2'h2), .addr_select_low(2'h1),
    .smb_clk(smb_clk), .serial_data_pin_in(sda_line), .serial_data_pin_out(sda_out),
    .serial_data_pin_oe(sda_oe), .alert_out(alert_out), .alert_oe(alert_oe),
    .adc_data(adc_data), .adc_done(adc_done), .remote_open(remote_open),
    .adc_start(adc_start), .adc_remote(adc_remote));
  tmc_adc_model adc (.clock(clock), .rst_n(rst_n), .adc_start(adc_start), .adc_remote(adc_remote),
    .lbase(lbase), .rbase(rbase), .adc_done(adc_done), .adc_data(adc_data));
  // ==========================================================
  // Bus tasks
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    int n;
    n = 0;
    req <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: {2'h0, i, 2'h0}, pwdata: {24'h0, d}};
    @(posedge clock);
    req.penable <= 1'h1;
    do @(posedge clock); while (rsp.pready !== 1'h1 && ++n < 50);
    if (rsp.pready !== 1'h1) begin
      n_errors++;
      $display("CHECK FAILED t=%0t no ready", $time);
    end
    q = rsp.prdata[7:0];
    e = rsp.pslverr;
    req <= '0;
    @(posedge clock);
  endtask : apb
  task rd(input logic [7:0] i); apb(1'h0, i, 8'h00); endtask : rd
  task wr(input logic [7:0] i, input logic [7:0] d); apb(1'h1, i, d); endtask : wr
  task automatic poll(input logic [7:0] i, input logic [7:0] m, input logic [7:0] v);
    int n;
    n = 0;
    do begin rd(i); n++; end while ((q & m) !== v && n < 300);
  endtask : poll
  // One bit per 200 ns link period, data changed while the clock is low
  task sbit(input logic b);
    sda <= b;
    repeat (4) @(posedge clock);
    smb_clk <= 1'h1;
    repeat (4) @(posedge clock);
    ack = !sda_line;
    smb_clk <= 1'h0;
  endtask : sbit
  task sbyte(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) sbit(d[i]);
    sbit(1'h1);
  endtask : sbyte
  // ==========================================================
  // Scenarios
  task t_boot;
    for (int i = 0; i < 9; i++) begin
      rd(i[7:0]);
      `CHK(q, rv[i])
    end
    `CHK(alert_oe, 1'h1)
  endtask : t_boot
  task t_refuse;
    rd(8'h09);
    `CHK({e, q}, 9'h100)
    wr(8'h03, 8'h55);
    `CHK(e, 1'h1)
    wr(8'h0A, 8'h09);
    rd(8'h04);
    `CHK({e, q}, 9'h009)
    rd(8'h03);
    `CHK(q, 8'h00)
  endtask : t_refuse
  task t_clear;
    wr(8'h0C, 8'h80);
    wr(8'h0E, 8'h80);
    rd(8'h02);
    `CHK(q, 8'h28)
    rd(8'h02);
    `CHK(q, 8'h00)
    repeat (3) @(posedge clock);
    `CHK(alert_oe, 1'h0)
  endtask : t_clear
  task t_smb;
    sda <= 1'h0;
    repeat (4) @(posedge clock);
    smb_clk <= 1'h0;
    sbyte(8'h3E);
    `CHK(ack, 1'h1)
    sbyte(8'h06);
    `CHK(ack, 1'h1)
    // Repeated start, then read back the register that the pointer names
    sda <= 1'h1;
    repeat (4) @(posedge clock);
    smb_clk <= 1'h1;
    repeat (4) @(posedge clock);
    sda <= 1'h0;
    repeat (4) @(posedge clock);
    smb_clk <= 1'h0;
    sbyte(8'h3F);
    `CHK(ack, 1'h1)
    for (int i = 7; i >= 0; i--) begin
      sbit(1'h1);
      q[i] = !ack;
    end
    sbit(1'h1);
    `CHK(q, 8'h80)
    sda <= 1'h0;
    repeat (4) @(posedge clock);
    smb_clk <= 1'h1;
    repeat (4) @(posedge clock);
    sda <= 1'h1;
    repeat (4) @(posedge clock);
  endtask : t_smb
  task t_run;
    standby_select_n <= 1'h1;
    poll(8'h01, 8'hFF, 8'h32);
    `CHK(q, 8'h32)
    rd(8'h00);
    `CHK(q, 8'h19)
    rd(8'h02);
    `CHK(q & 8'h7C, 8'h00)
    `CHK(alert_oe, 1'h0)
  endtask : t_run
  task t_limit;
    wr(8'h0B, 8'h18);
    wr(8'h0D, 8'h32);
    poll(8'h02, 8'h7C, 8'h40);
    `CHK(q & 8'h7C, 8'h40)
    repeat (2) @(posedge clock);
    `CHK(alert_oe, 1'h1)
    wr(8'h09, 8'h80);
    repeat (2) @(posedge clock);
    `CHK(alert_oe, 1'h0)
    wr(8'h0B, 8'h7F);
    wr(8'h09, 8'h00);
    poll(8'h02, 8'h7C, 8'h00);
    `CHK(q & 8'h7C, 8'h00)
  endtask : t_limit
  // Software standby holds the values; a one-shot then runs one round
  task t_oneshot;
    wr(8'h09, 8'h40);
    poll(8'h02, 8'h80, 8'h00);
    lbase <= 8'h20;
    repeat (300) @(posedge clock);
    rd(8'h00);
    `CHK(q, 8'h19)
    wr(8'h0F, 8'h00);
    poll(8'h00, 8'hFF, 8'h21);
    `CHK(q, 8'h21)
    remote_open <= 1'h1;
    repeat (4) @(posedge clock);
    remote_open <= 1'h0;
    repeat (4) @(posedge clock);
    `CHK(alert_oe, 1'h1)
    rd(8'h02);
    `CHK(q & 8'h7C, 8'h04)
    rd(8'h02);
    `CHK(q & 8'h7C, 8'h00)
    `CHK(alert_oe, 1'h0)
  endtask : t_oneshot
  task results;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'h1;
    repeat (4) @(posedge clock);
    t_boot;
    t_refuse;
    t_clear;
    t_smb;
    t_run;
    t_limit;
    t_oneshot;
    results;
  end
  // Polls are bounded well below this span
  initial begin
    #1000000;
    n_errors++;
    results;
  end
endmodule : tb_temp_monitor_compare_alert
`default_nettype wire
